/* src/tef_params.svh */
// constants for the transient earth fault stage
`ifndef TEF_PARAMS_SVH
`define TEF_PARAMS_SVH
`define TEF_CLK_HZ 10000000
`define TEF_SAMPLE_US 625
`define TEF_TICK_CYC (`TEF_SAMPLE_US * (`TEF_CLK_HZ / 1000000))
`define TEF_SMP_PER_CYC 32
`define TEF_STEP_MS 10
`define TEF_STEP_TICKS (`TEF_STEP_MS * 1000 / `TEF_SAMPLE_US)
`define TEF_OFS_CFG0 4'h0
`define TEF_OFS_CFG1 4'h4
`define TEF_OFS_INTT 4'h8
`define TEF_OFS_RSTD 4'hc
`define TEF_GRP_STRIDE 8'h10
`define TEF_OFS_CTRL 8'h40
`define TEF_OFS_STATUS 8'h44
`define TEF_PEAKS_LSB 16
`define TEF_SENS_BIT 8
`define TEF_DIR_BIT 9
`define TEF_PEAKS_MIN 5'd1
`define TEF_PEAKS_MAX 5'd20
`define TEF_OPDLY_MAX 14'd15000
`define TEF_INTT_MAX 15'd30000
`define TEF_RSTD_MIN 15'd6
`define TEF_RSTD_MAX 15'd30000
`define TEF_ULVL_MIN 7'd1
`define TEF_ULVL_MAX 7'd60
`define TEF_RST_PEAKS 5'd2
`define TEF_RST_OPDLY 14'd8
`define TEF_RST_INTT 15'd20
`define TEF_RST_RSTD 15'd6
`define TEF_RST_ULVL 7'd10
`define TEF_I0_NOM 16'h2000
`define TEF_I0_THR_NORM (`TEF_I0_NOM / 10)
`define TEF_I0_THR_SENS (`TEF_I0_NOM / 40)
`define TEF_U0_NOM 16'h4000
`define TEF_HYST_PERMIL 97
`endif

/* src/tef_peak_detect.sv */
// residual current transient peak and direction detector
`timescale 1ns/1ns
`include "tef_params.svh"
module tef_peak_detect (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input tef_pkg::sample_t residual_current,
	input tef_pkg::sample_t neutral_displacement_voltage,
	input wire logic sens,
	input wire logic dir_rev,
	output logic peak
);
	import tef_pkg::*;
	mag_t i_abs;
	mag_t thr;
	mag_t cyc_max_r;
	mag_t fund_pk_r;
	logic [4:0] idx_r;
	logic over_r;
	logic over;
	logic dir_ok;
	assign i_abs = residual_current[15] ? 16'(-residual_current) : 16'(residual_current);
	assign thr = sens ? 16'(`TEF_I0_THR_SENS) : 16'(`TEF_I0_THR_NORM);
	// direction from sign relation, not amplitude
	assign dir_ok = (residual_current[15] != neutral_displacement_voltage[15]) ^ dir_rev;
	assign over = (i_abs > thr) && (i_abs > fund_pk_r) && dir_ok;
	// --------------------------------
	// previous power cycle sample peak
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_r <= 5'h0;
			cyc_max_r <= 16'h0;
			fund_pk_r <= 16'hffff;
		end else if (tick) begin
			idx_r <= idx_r + 5'h1;
			if (idx_r == 5'(`TEF_SMP_PER_CYC - 1)) begin
				fund_pk_r <= (i_abs > cyc_max_r) ? i_abs : cyc_max_r;
				cyc_max_r <= 16'h0;
			end else if (i_abs > cyc_max_r) begin
				cyc_max_r <= i_abs;
			end
		end
	end
	// --------------------------------
	// one pulse per new excursion
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			over_r <= 1'b0;
			peak <= 1'b0;
		end else begin
			peak <= tick && over && !over_r;
			if (tick) begin
				over_r <= over;
			end
		end
	end
	peak_above_fund_a: assert property (@(posedge pclk) disable iff (!presetn)
		peak |-> $past(i_abs > fund_pk_r && i_abs > thr))
		else $error("peak flagged below fundamental peak or threshold");
endmodule : tef_peak_detect

/* src/tef_pkg.sv */
// types for the transient earth fault stage
package tef_pkg;
	typedef logic signed [15:0] sample_t;
	typedef logic [15:0] mag_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_TRIP = 2'b11,
		ST_HOLD = 2'b10
	} stage_state_t;
endpackage : tef_pkg

/* src/tef_u0_level.sv */
// neutral displacement voltage level with release hysteresis
`timescale 1ns/1ns
`include "tef_params.svh"
module tef_u0_level (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input tef_pkg::sample_t neutral_displacement_voltage,
	input wire logic [6:0] level_pct,
	output logic u_ok
);
	import tef_pkg::*;
	mag_t u_abs;
	mag_t cyc_max_r;
	mag_t pk;
	logic [4:0] idx_r;
	logic [31:0] pk_scaled;
	logic [31:0] start_lim;
	logic [31:0] rel_lim;
	assign u_abs = neutral_displacement_voltage[15] ? 16'(-neutral_displacement_voltage)
		: 16'(neutral_displacement_voltage);
	assign pk = (u_abs > cyc_max_r) ? u_abs : cyc_max_r;
	assign pk_scaled = {16'h0, pk} * 32'd10000;
	assign start_lim = {25'h0, level_pct} * 32'(`TEF_U0_NOM) * 32'd100;
	assign rel_lim = {25'h0, level_pct} * 32'(`TEF_U0_NOM) * 32'(`TEF_HYST_PERMIL);
	// --------------------------------
	// per cycle level decision
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx_r <= 5'h0;
			cyc_max_r <= 16'h0;
			u_ok <= 1'b0;
		end else if (tick) begin
			idx_r <= idx_r + 5'h1;
			if (idx_r == 5'(`TEF_SMP_PER_CYC - 1)) begin
				cyc_max_r <= 16'h0;
				if (pk_scaled >= start_lim) begin
					u_ok <= 1'b1;
				end else if (pk_scaled < rel_lim) begin
					u_ok <= 1'b0;
				end
			end else begin
				cyc_max_r <= pk;
			end
		end
	end
	u_hyst_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(u_ok) |-> $past(pk_scaled < rel_lim && tick))
		else $error("voltage released above hysteresis limit");
endmodule : tef_u0_level

/* src/transient_earth_fault_stage.sv */
// transient intermittent earth fault stage with apb settings
`timescale 1ns/1ns
`include "tef_params.svh"
module transient_earth_fault_stage #(
	parameter int TICK_CYC = `TEF_TICK_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input tef_pkg::sample_t residual_current,
	input tef_pkg::sample_t neutral_displacement_voltage,
	input wire logic reclose_block,
	output logic stage_start,
	output logic stage_trip
);
	import tef_pkg::*;
	// --------------------------------
	// setting groups
	// --------------------------------
	logic [4:0] peaks_r [4];
	logic [13:0] opdly_r [4];
	logic [6:0] ulvl_r [4];
	logic sens_r [4];
	logic dir_r [4];
	logic [14:0] intt_r [4];
	logic [14:0] rstd_r [4];
	logic [1:0] grp_r;
	logic [1:0] wgrp;
	logic [3:0] wofs;
	logic grp_hit;
	logic [4:0] w_peaks;
	logic [13:0] w_op;
	logic [14:0] w_t;
	logic [6:0] w_lvl;
	logic bad;
	logic [31:0] rd;
	logic wr;
	// --------------------------------
	// sample tick and 10 ms step
	// --------------------------------
	logic [12:0] tick_cnt_r;
	logic tick_r;
	logic [3:0] step_cnt_r;
	logic step_r;
	// --------------------------------
	// stage state
	// --------------------------------
	stage_state_t state_r;
	stage_state_t state_nxt;
	logic [4:0] cnt_r;
	logic [15:0] op_tmr_r;
	logic [14:0] int_tmr_r;
	logic [14:0] rst_tmr_r;
	logic op_done;
	logic int_done;
	logic rst_done;
	logic cnt_met;
	logic trip_ok;
	logic peak;
	logic u_ok;
	logic blk_m_r;
	logic blk_s_r;
	sample_t i_smp_r;
	sample_t u_smp_r;
	assign wgrp = paddr[5:4];
	assign wofs = paddr[3:0];
	assign grp_hit = (paddr[7:6] == 2'b00);
	assign w_peaks = pwdata[`TEF_PEAKS_LSB +: 5];
	assign w_op = pwdata[13:0];
	assign w_t = pwdata[14:0];
	assign w_lvl = pwdata[6:0];
	// --------------------------------
	// address decode and validation
	// --------------------------------
	always_comb begin
		bad = 1'b0;
		rd = 32'h0;
		if (grp_hit) begin
			unique case (wofs)
				`TEF_OFS_CFG0: begin
					rd = {11'h0, peaks_r[wgrp], 2'h0, opdly_r[wgrp]};
					bad = pwrite && (w_peaks < `TEF_PEAKS_MIN || w_peaks > `TEF_PEAKS_MAX
						|| w_op == 14'h0 || w_op > `TEF_OPDLY_MAX
						|| {10'h0, w_peaks} > {w_op, 1'b0});
				end
				`TEF_OFS_CFG1: begin
					rd = {22'h0, dir_r[wgrp], sens_r[wgrp], 1'b0, ulvl_r[wgrp]};
					bad = pwrite && (w_lvl < `TEF_ULVL_MIN || w_lvl > `TEF_ULVL_MAX);
				end
				`TEF_OFS_INTT: begin
					rd = {17'h0, intt_r[wgrp]};
					bad = pwrite && (w_t == 15'h0 || w_t > `TEF_INTT_MAX);
				end
				`TEF_OFS_RSTD: begin
					rd = {17'h0, rstd_r[wgrp]};
					bad = pwrite && (w_t < `TEF_RSTD_MIN || w_t > `TEF_RSTD_MAX);
				end
				default: begin
					bad = 1'b1;
				end
			endcase
		end else if (paddr == `TEF_OFS_CTRL) begin
			rd = {30'h0, grp_r};
		end else if (paddr == `TEF_OFS_STATUS) begin
			rd = {16'h0, cnt_r, 3'h0, blk_s_r, u_ok, state_r, 2'h0, stage_trip, stage_start};
			bad = pwrite;
		end else begin
			bad = 1'b1;
		end
	end
	// --------------------------------
	// apb answer, one cycle after setup
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && bad;
			prdata <= (psel && !penable && !pwrite && !bad) ? rd : 32'h0;
		end
	end
	assign wr = psel && penable && pready && pwrite && !pslverr;
	// --------------------------------
	// setting storage
	// --------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : grp_g
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					peaks_r[g] <= `TEF_RST_PEAKS;
					opdly_r[g] <= `TEF_RST_OPDLY;
					ulvl_r[g] <= `TEF_RST_ULVL;
					sens_r[g] <= 1'b0;
					dir_r[g] <= 1'b0;
					intt_r[g] <= `TEF_RST_INTT;
					rstd_r[g] <= `TEF_RST_RSTD;
				end else if (wr && grp_hit && wgrp == 2'(g)) begin
					if (wofs == `TEF_OFS_CFG0) begin
						peaks_r[g] <= w_peaks;
						opdly_r[g] <= w_op;
					end
					if (wofs == `TEF_OFS_CFG1) begin
						ulvl_r[g] <= w_lvl;
						sens_r[g] <= pwdata[`TEF_SENS_BIT];
						dir_r[g] <= pwdata[`TEF_DIR_BIT];
					end
					if (wofs == `TEF_OFS_INTT) begin
						intt_r[g] <= w_t;
					end
					if (wofs == `TEF_OFS_RSTD) begin
						rstd_r[g] <= w_t;
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			grp_r <= 2'h0;
		end else if (wr && paddr == `TEF_OFS_CTRL) begin
			grp_r <= pwdata[1:0];
		end
	end
	// --------------------------------
	// timebase
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_r <= 13'h0;
			tick_r <= 1'b0;
			step_cnt_r <= 4'h0;
			step_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 13'(TICK_CYC - 1));
			tick_cnt_r <= (tick_cnt_r == 13'(TICK_CYC - 1)) ? 13'h0 : tick_cnt_r + 13'h1;
			step_r <= tick_r && (step_cnt_r == 4'(`TEF_STEP_TICKS - 1));
			if (tick_r) begin
				step_cnt_r <= step_cnt_r + 4'h1;
			end
		end
	end
	// --------------------------------
	// sample capture and block sync
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			i_smp_r <= 16'sh0;
			u_smp_r <= 16'sh0;
		end else if (tick_r) begin
			i_smp_r <= residual_current;
			u_smp_r <= neutral_displacement_voltage;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blk_m_r <= 1'b0;
			blk_s_r <= 1'b0;
		end else begin
			blk_m_r <= reclose_block;
			blk_s_r <= blk_m_r;
		end
	end
	tef_peak_detect peak_u (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_r),
		.residual_current(i_smp_r),
		.neutral_displacement_voltage(u_smp_r),
		.sens(sens_r[grp_r]),
		.dir_rev(dir_r[grp_r]),
		.peak(peak)
	);
	tef_u0_level u0_u (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_r),
		.neutral_displacement_voltage(u_smp_r),
		.level_pct(ulvl_r[grp_r]),
		.u_ok(u_ok)
	);
	// --------------------------------
	// stage sequencing
	// --------------------------------
	assign op_done = (op_tmr_r >= {1'b0, opdly_r[grp_r], 1'b0});
	assign int_done = (int_tmr_r >= intt_r[grp_r]);
	assign rst_done = (rst_tmr_r >= rstd_r[grp_r]);
	assign cnt_met = (cnt_r >= peaks_r[grp_r]);
	assign trip_ok = op_done && cnt_met && u_ok && !int_done;
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE: begin
				if (peak) begin
					state_nxt = ST_START;
				end
			end
			ST_START: begin
				if (trip_ok) begin
					state_nxt = ST_TRIP;
				end else if (int_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_TRIP: begin
				if (int_done || !u_ok) begin
					state_nxt = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (peak && u_ok) begin
					state_nxt = ST_TRIP;
				end else if (rst_done) begin
					state_nxt = ST_IDLE;
				end
			end
		endcase
		if (blk_s_r) begin
			state_nxt = ST_IDLE;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end
	// peak counter, cleared on release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 5'h0;
		end else if (state_nxt == ST_IDLE) begin
			cnt_r <= 5'h0;
		end else if (peak && cnt_r != 5'h1f) begin
			cnt_r <= cnt_r + 5'h1;
		end
	end
	// operation delay from first peak
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_tmr_r <= 16'h0;
		end else if (state_r == ST_IDLE) begin
			op_tmr_r <= 16'h0;
		end else if (step_r && !op_done) begin
			op_tmr_r <= op_tmr_r + 16'h1;
		end
	end
	// intermittent window restarts on each peak
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_tmr_r <= 15'h0;
		end else if (state_r == ST_IDLE || peak) begin
			int_tmr_r <= 15'h0;
		end else if (step_r && !int_done) begin
			int_tmr_r <= int_tmr_r + 15'h1;
		end
	end
	// reset delay runs only while holding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_tmr_r <= 15'h0;
		end else if (state_r != ST_HOLD) begin
			rst_tmr_r <= 15'h0;
		end else if (step_r && !rst_done) begin
			rst_tmr_r <= rst_tmr_r + 15'h1;
		end
	end
	// --------------------------------
	// outputs
	// --------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_start <= 1'b0;
			stage_trip <= 1'b0;
		end else begin
			stage_start <= (state_nxt != ST_IDLE);
			stage_trip <= (state_nxt == ST_TRIP || state_nxt == ST_HOLD);
		end
	end
	// --------------------------------
	// checks
	// --------------------------------
	tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		tick_r |=> !tick_r)
		else $error("sample tick longer than one cycle");
	trip_all_met_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_START ##1 state_r == ST_TRIP |-> $past(op_done && cnt_met))
		else $error("trip entered without delay and peak count");
	trip_voltage_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(stage_trip) |-> $past(u_ok))
		else $error("trip raised without voltage above limit");
	hold_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_HOLD && !rst_done && !blk_s_r |=> stage_trip)
		else $error("trip dropped before reset delay");
	first_peak_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_IDLE && peak && !blk_s_r |=> state_r == ST_START ##1 stage_start)
		else $error("first peak did not start the stage");
	late_peak_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_START && trip_ok && !blk_s_r |=> state_r == ST_TRIP ##1 stage_trip)
		else $error("late last peak did not trip at once");
	window_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_START && int_done && !trip_ok |=> state_r == ST_IDLE && cnt_r == 5'h0)
		else $error("window expiry did not release and clear");
	block_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		blk_s_r |=> !stage_start && !stage_trip)
		else $error("outputs active while blocked");
	setting_sane_a: assert property (@(posedge pclk) disable iff (!presetn)
		{10'h0, peaks_r[grp_r]} <= {opdly_r[grp_r], 1'b0})
		else $error("stored peak count exceeds delay allowance");
endmodule : transient_earth_fault_stage

/* testbench/tb.sv */
// self-checking bench for the transient earth fault stage
`timescale 1ns/1ns
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, s); end end
module tb;
	import tef_pkg::*;
	localparam int TK = 16;
	localparam int ST = 16 * TK;
	localparam sample_t NEG = -16'sh1000;
	localparam logic [4:0] POS = 5'b00110;
	localparam logic [4:0] SENS = 5'b10000;
	localparam logic [4:0] REV = 5'b00100;
	localparam logic [4:0] EXP = 5'b10101;
	logic pclk, presetn, psel, penable, pwrite, reclose_block, pready, pslverr, stage_start, stage_trip, brk;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, lvl;
	logic [15:0] mag;
	logic [32:0] exp_q[$];
	logic [32:0] e_r;
	sample_t i0, u0;
	int n_fail = 0;
	int total_checks = 0;
	transient_earth_fault_stage #(.TICK_CYC(TK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .residual_current(i0), .neutral_displacement_voltage(u0),
		.reclose_block(reclose_block), .stage_start(stage_start), .stage_trip(stage_trip));
	tef_front_end #(.TICK(TK), .BRK_CYC(40)) fe (.pclk(pclk), .trip(stage_trip), .residual_current(i0),
		.neutral_displacement_voltage(u0), .breaker_open(brk));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ----------------------------------------
	// bus and wait helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		int n;
		n = 0;
		exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20)
			n_fail++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(1'b1, a, d, {err, 32'h0});
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic err);
		apb(1'b0, a, d, {err, d});
	endtask : rd
	task automatic wait_out(input logic [1:0] e, input int lim);
		int n;
		n = 0;
		while ({stage_start, stage_trip} !== e && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if ({stage_start, stage_trip} !== e)
			n_fail++;
	endtask : wait_out
	task automatic settle();
		wait_out(2'b00, 24 * ST);
		cyc(64 * TK);
	endtask : settle
	function automatic logic [31:0] cf(input int p, input int o);
		return (32'(p) << 16) | 32'(o);
	endfunction : cf
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : summarize
	// ----------------------------------------
	// response monitor
	// ----------------------------------------
	always @(posedge pclk) begin
		if (psel && !penable)
			`CHK("pready setup", 1'b0, pready)
		if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
			e_r = exp_q.pop_front();
			`CHK("apb response", e_r, {pslverr, prdata})
		end
	end
	initial begin
		cyc(95000);
		n_fail++;
		summarize();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		reclose_block = 1'b0;
		void'($urandom(32'h646aaa48));
		cyc(5);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 32'h00020008, 1'b0);
		rd(8'h04, 32'h0000000a, 1'b0);
		rd(8'h08, 32'h00000014, 1'b0);
		rd(8'h0c, 32'h00000006, 1'b0);
		rd(8'h30, 32'h00020008, 1'b0);
		rd(8'h40, 32'h00000000, 1'b0);
		rd(8'h48, 32'h00000000, 1'b1);
		wr(8'h44, 32'h0, 1'b1);
		wr(8'h00, cf(21, 15000), 1'b1);
		wr(8'h00, cf(1, 0), 1'b1);
		wr(8'h00, cf(1, 15001), 1'b1);
		wr(8'h00, cf(10, 4), 1'b1);
		wr(8'h00, cf(8, 4), 1'b0);
		rd(8'h00, cf(8, 4), 1'b0);
		wr(8'h00, cf(2, 8), 1'b0);
		wr(8'h04, 32'd61, 1'b1);
		wr(8'h08, 32'd0, 1'b1);
		wr(8'h08, 32'd30001, 1'b1);
		wr(8'h0c, 32'd5, 1'b1);
		wr(8'h0c, 32'd30000, 1'b0);
		wr(8'h0c, 32'd6, 1'b0);
		lvl = 1 + $urandom % 60;
		wr(8'h24, lvl, 1'b0);
		rd(8'h24, lvl, 1'b0);
		rd(8'h04, 32'h0000000a, 1'b0);
		wr(8'h40, 32'h2, 1'b0);
		rd(8'h40, 32'h2, 1'b0);
		wr(8'h40, 32'h0, 1'b0);
		fe.set_u(16'sh2000);
		cyc(64 * TK);
		fe.spike(NEG);
		cyc(8 * ST - TK);
		fe.spike(NEG);
		cyc(6 * ST - TK);
		`CHK("start before delay", 2'b10, {stage_start, stage_trip})
		wait_out(2'b11, 4 * ST);
		`CHK("trip at delay", 2'b11, {stage_start, stage_trip})
		cyc(5 * ST);
		`CHK("reset hold", 2'b11, {stage_start, stage_trip})
		wait_out(2'b00, 16 * ST);
		`CHK("hold release", 2'b00, {stage_start, stage_trip})
		fe.reclose();
		cyc(64 * TK);
		fe.spike(NEG);
		cyc(14 * ST - TK);
		`CHK("one peak start", 2'b10, {stage_start, stage_trip})
		cyc(4 * ST);
		`CHK("delay passed", 2'b10, {stage_start, stage_trip})
		cyc(5 * ST);
		`CHK("window release", 2'b00, {stage_start, stage_trip})
		cyc(40 * TK);
		fe.spike(NEG);
		cyc(18 * ST - TK);
		fe.spike(NEG);
		cyc(TK + 4);
		`CHK("late peak trip", 2'b11, {stage_start, stage_trip})
		wait_out(2'b00, 30 * ST);
		fe.reclose();
		cyc(64 * TK);
		wr(8'h08, 32'd5, 1'b0);
		fe.spike(NEG);
		cyc(3 * ST - TK);
		`CHK("short window start", 2'b10, {stage_start, stage_trip})
		cyc(5 * ST);
		`CHK("short window release", 2'b00, {stage_start, stage_trip})
		fe.spike(NEG);
		cyc(3 * ST - TK);
		`CHK("count cleared", 2'b10, {stage_start, stage_trip})
		rd(8'h44, 32'h00000851, 1'b0);
		cyc(5 * ST);
		`CHK("no trip", 2'b00, {stage_start, stage_trip})
		wr(8'h08, 32'd20, 1'b0);
		cyc(40 * TK);
		fe.set_u(16'sh0100);
		cyc(64 * TK);
		fe.spike(NEG);
		cyc(8 * ST - TK);
		fe.spike(NEG);
		cyc(12 * ST);
		`CHK("low voltage trip", 1'b0, stage_trip)
		settle();
		fe.set_u(16'sh2000);
		cyc(64 * TK);
		for (int k = 0; k < 5; k++) begin
			mag = (k < 3) ? 16'h0400 + 16'($urandom % 32'h3000) : 16'h0200;
			wr(8'h04, 32'h0a | (32'(SENS[k]) << 8) | (32'(REV[k]) << 9), 1'b0);
			fe.spike(POS[k] ? sample_t'(mag) : -sample_t'(mag));
			cyc(TK + 4);
			`CHK("peak start", EXP[k], stage_start)
			settle();
		end
		wr(8'h04, 32'h0a, 1'b0);
		reclose_block <= 1'b1;
		cyc(8);
		fe.spike(NEG);
		cyc(TK + 4);
		`CHK("blocked start", 2'b00, {stage_start, stage_trip})
		reclose_block <= 1'b0;
		cyc(64 * TK);
		fe.spike(NEG);
		cyc(TK + 4);
		`CHK("start out", 2'b10, {stage_start, stage_trip})
		reclose_block <= 1'b1;
		cyc(6);
		`CHK("block forces off", 2'b00, {stage_start, stage_trip})
		reclose_block <= 1'b0;
		settle();
		summarize();
	end
endmodule : tb

/* testbench/tef_front_end.sv */
// sample source and breaker model facing the transient earth fault stage
`timescale 1ns/1ns
module tef_front_end #(
	parameter int TICK = 16,
	parameter int BRK_CYC = 40
) (
	input wire logic pclk,
	input wire logic trip,
	output tef_pkg::sample_t residual_current,
	output tef_pkg::sample_t neutral_displacement_voltage,
	output logic breaker_open
);
	import tef_pkg::*;
	sample_t i_r = '0;
	sample_t u_r = '0;
	int trip_cnt_r = 0;
	initial breaker_open = 1'b0;
	// an open breaker removes both current and voltage
	assign residual_current = breaker_open ? '0 : i_r;
	assign neutral_displacement_voltage = breaker_open ? '0 : u_r;
	always @(posedge pclk) begin
		trip_cnt_r <= trip ? trip_cnt_r + 1 : 0;
		if (trip_cnt_r == BRK_CYC)
			breaker_open <= 1'b1;
	end
	task automatic set_u(input sample_t v);
		@(posedge pclk);
		u_r <= v;
	endtask : set_u
	// one sample long transient, sign against voltage sets direction
	task automatic spike(input sample_t a);
		@(posedge pclk);
		i_r <= a;
		repeat (TICK) @(posedge pclk);
		i_r <= '0;
	endtask : spike
	task automatic reclose();
		@(posedge pclk);
		breaker_open <= 1'b0;
	endtask : reclose
endmodule : tef_front_end
